// *** design/acrc_cfg_bank.sv ***
/*
  byte-wide configuration and status bank: receiver modes for the sample
  clock, SYSREF and timestamp inputs, edge-position status, per-input
  range codes, reference bypass and global lane pre-emphasis.
  assumes a byte-wide configuration port on ref_clk: one-cycle write and
  read strobes with a 12-bit byte address; read data answers next cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "acrc_regs.svh"
module acrc_cfg_bank #(
  parameter int LANES = 16
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic                       clk_en,
  // configuration port
  input  wire logic [`ACRC_ADDR_W-1:0]    cfg_addr,
  input  wire logic                       cfg_wr,
  input  wire logic                       cfg_rd,
  input  wire acrc_pkg::acrc_byte_t       cfg_wdata,
  output var  acrc_pkg::acrc_byte_t       cfg_rdata,
  output var  logic                       cfg_rvalid,
  // status from the sample-clock domain
  input  wire acrc_pkg::acrc_pos_t        sysref_edge_position,
  // raw SYSREF from its receiver
  input  wire logic                       sysref_raw,
  // analog and receiver controls
  output var  logic                       devclock_low_swing_mode,
  output var  logic                       sysref_low_swing_mode,
  output var  logic                       sysref_polarity_flip,
  output var  logic                       sysref_aligned,
  output var  logic                       sysref_position_fine_view,
  output var  acrc_pkg::acrc_code_t       sysref_delay_select,
  output var  logic                       sysref_auto_cal,
  output var  acrc_pkg::acrc_range_t      input_a_range_code,
  output var  acrc_pkg::acrc_range_t      input_b_range_code,
  output var  logic                       reference_bypass_select,
  output var  logic                       timestamp_low_swing_mode,
  output var  logic                       timestamp_receiver_enable,
  output var  logic [LANES*4-1:0]         lane_preemphasis_code
);
  import acrc_pkg::*;

  acrc_byte_t  clk_ctrl0_reg;
  acrc_byte_t  clock_input_control_1_reg;
  acrc_range_t range_a_reg;
  acrc_range_t range_b_reg;
  acrc_byte_t  bypass_reg;
  acrc_byte_t  tstamp_reg;
  acrc_byte_t  preemph_reg;
  acrc_pos_t   pos_sync;
  acrc_byte_t  rdata_next;
  logic        sysref_m_reg;
  logic        sysref_s_reg;

  acrc_pos_sync #(.WIDTH(24)) u_pos_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in (sysref_edge_position),
    .sync_out (pos_sync)
  );

  // writes; reserved bits are stored and read back unchanged
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      clk_ctrl0_reg <= `ACRC_CLK_CTRL0_RST;
      clock_input_control_1_reg <= `ACRC_CLOCK_INPUT_CONTROL_1_RST;
      range_a_reg   <= `ACRC_RANGE_RST;
      range_b_reg   <= `ACRC_RANGE_RST;
      bypass_reg    <= `ACRC_BYPASS_RST;
      tstamp_reg    <= `ACRC_TSTAMP_RST;
      preemph_reg   <= `ACRC_PREEMPH_RST;
    end else if (clk_en && cfg_wr) begin
      if (cfg_addr == `ACRC_CLK_CTRL0_OFF) begin
        clk_ctrl0_reg <= cfg_wdata;
      end else if (cfg_addr == `ACRC_CLOCK_INPUT_CONTROL_1_OFF) begin
        clock_input_control_1_reg <= cfg_wdata;
      end else if (cfg_addr == `ACRC_RANGE_A_OFF0) begin
        range_a_reg[15:8] <= cfg_wdata;
      end else if (cfg_addr == `ACRC_RANGE_A_OFF1) begin
        range_a_reg[7:0] <= cfg_wdata;
      end else if (cfg_addr == `ACRC_RANGE_B_OFF0) begin
        range_b_reg[15:8] <= cfg_wdata;
      end else if (cfg_addr == `ACRC_RANGE_B_OFF1) begin
        range_b_reg[7:0] <= cfg_wdata;
      end else if (cfg_addr == `ACRC_BYPASS_OFF) begin
        bypass_reg <= cfg_wdata;
      end else if (cfg_addr == `ACRC_TSTAMP_OFF) begin
        tstamp_reg <= cfg_wdata;
      end else if (cfg_addr == `ACRC_PREEMPH_OFF) begin
        preemph_reg <= cfg_wdata;
      end
    end
  end

  // read mux; unmapped addresses read zero, writes to them are dropped
  always_comb begin
    rdata_next = 8'h00;
    if (cfg_addr == `ACRC_CLK_CTRL0_OFF) begin
      rdata_next = clk_ctrl0_reg;
    end else if (cfg_addr == `ACRC_CLOCK_INPUT_CONTROL_1_OFF) begin
      rdata_next = clock_input_control_1_reg;
    end else if (cfg_addr == `ACRC_POS_OFF0) begin
      rdata_next = pos_sync[23:16];
    end else if (cfg_addr == `ACRC_POS_OFF1) begin
      rdata_next = pos_sync[15:8];
    end else if (cfg_addr == `ACRC_POS_OFF2) begin
      rdata_next = pos_sync[7:0];
    end else if (cfg_addr == `ACRC_RANGE_A_OFF0) begin
      rdata_next = range_a_reg[15:8];
    end else if (cfg_addr == `ACRC_RANGE_A_OFF1) begin
      rdata_next = range_a_reg[7:0];
    end else if (cfg_addr == `ACRC_RANGE_B_OFF0) begin
      rdata_next = range_b_reg[15:8];
    end else if (cfg_addr == `ACRC_RANGE_B_OFF1) begin
      rdata_next = range_b_reg[7:0];
    end else if (cfg_addr == `ACRC_BYPASS_OFF) begin
      rdata_next = bypass_reg;
    end else if (cfg_addr == `ACRC_TSTAMP_OFF) begin
      rdata_next = tstamp_reg;
    end else if (cfg_addr == `ACRC_PREEMPH_OFF) begin
      rdata_next = preemph_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfg_rdata  <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else if (clk_en) begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= rdata_next;
      end
    end
  end

  // controls are registered from the stored bits; auto-cal is set while the delay select is zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      devclock_low_swing_mode   <= 1'b0;
      sysref_low_swing_mode     <= 1'b0;
      sysref_polarity_flip      <= 1'b0;
      sysref_position_fine_view <= 1'b0;
      sysref_delay_select       <= 4'h0;
      sysref_auto_cal           <= 1'b1;
      input_a_range_code        <= `ACRC_RANGE_RST;
      input_b_range_code        <= `ACRC_RANGE_RST;
      reference_bypass_select   <= 1'b0;
      timestamp_low_swing_mode  <= 1'b0;
      timestamp_receiver_enable <= 1'b0;
    end else if (clk_en) begin
      devclock_low_swing_mode   <= clock_input_control_1_reg[`ACRC_DEVICE_SAMPLE_CLOCK_LS_BIT];
      sysref_low_swing_mode     <= clock_input_control_1_reg[`ACRC_SYSREF_LS_BIT];
      sysref_polarity_flip      <= clock_input_control_1_reg[`ACRC_SYSREF_FLIP_BIT];
      // the analog side picks the coarse or fine position scale
      sysref_position_fine_view <= clk_ctrl0_reg[`ACRC_FINE_VIEW_BIT];
      // software picks this tap from the edge-position readout
      sysref_delay_select       <= clk_ctrl0_reg[`ACRC_SEL_MSB:0];
      sysref_auto_cal <= (clk_ctrl0_reg[`ACRC_SEL_MSB:0] == 4'h0);
      // codes below 0x2000 are passed through; software must avoid them
      input_a_range_code        <= range_a_reg;
      input_b_range_code        <= range_b_reg;
      reference_bypass_select   <= bypass_reg[`ACRC_BYPASS_BIT];
      timestamp_low_swing_mode  <= tstamp_reg[`ACRC_TS_LS_BIT];
      timestamp_receiver_enable <= tstamp_reg[`ACRC_TS_EN_BIT];
    end
  end

  // one code fanned out to every lane
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          lane_preemphasis_code[g*4 +: 4] <= 4'h0;
        end else if (clk_en) begin
          lane_preemphasis_code[g*4 +: 4] <= preemph_reg[`ACRC_PE_MSB:0];
        end
      end
    end
  endgenerate

  // SYSREF is a pin: two flops, then the optional inversion
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sysref_m_reg   <= 1'b0;
      sysref_s_reg   <= 1'b0;
      sysref_aligned <= 1'b0;
    end else if (clk_en) begin
      sysref_m_reg   <= sysref_raw;
      sysref_s_reg   <= sysref_m_reg;
      sysref_aligned <= sysref_s_reg ^ clock_input_control_1_reg[`ACRC_SYSREF_FLIP_BIT];
    end
  end

  device_sample_clock_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && cfg_wr && cfg_addr == `ACRC_CLOCK_INPUT_CONTROL_1_OFF) ##1 clk_en
    |=> devclock_low_swing_mode == $past(cfg_wdata[2], 2))
    else $error("sample clock mode not following control bit");
  sysref_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> sysref_low_swing_mode == $past(clock_input_control_1_reg[1]))
    else $error("sysref mode not following control bit");
  sysref_flip_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> sysref_aligned ==
      ($past(sysref_s_reg) ^ $past(clock_input_control_1_reg[0])))
    else $error("sysref inversion wrong");
  pos_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && cfg_rd && cfg_addr == `ACRC_POS_OFF0)
    |=> cfg_rvalid && cfg_rdata == $past(pos_sync[23:16]))
    else $error("position high byte misread");
  range_a_rst_a: assert property (@(posedge ref_clk)
    !rst_b |=> range_a_reg == 16'ha000 && input_a_range_code == 16'ha000)
    else $error("range a reset value wrong");
  range_b_rb_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && cfg_wr && cfg_addr == `ACRC_RANGE_B_OFF1)
    |=> range_b_reg[7:0] == $past(cfg_wdata))
    else $error("range b low byte not stored");
  bypass_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> reference_bypass_select == $past(bypass_reg[0]))
    else $error("bypass select wrong");
  ts_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> timestamp_low_swing_mode == $past(tstamp_reg[1]))
    else $error("timestamp mode wrong");
  ts_en_a: assert property (@(posedge ref_clk)
    !rst_b |=> !timestamp_receiver_enable)
    else $error("timestamp enable not cleared by reset");
  lane_pe_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> lane_preemphasis_code[LANES*4-1 -: 4] == $past(preemph_reg[3:0])
      && lane_preemphasis_code[3:0] == $past(preemph_reg[3:0]))
    else $error("lane pre-emphasis not common");
  fine_view_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> sysref_position_fine_view == $past(clk_ctrl0_reg[4]))
    else $error("fine view wrong");
  auto_cal_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> sysref_auto_cal == ($past(clk_ctrl0_reg[3:0]) == 4'h0))
    else $error("auto calibration select wrong");
  readback_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && cfg_wr && cfg_addr == `ACRC_PREEMPH_OFF) ##1
    (clk_en && cfg_rd && !cfg_wr && cfg_addr == `ACRC_PREEMPH_OFF)
    |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("pre-emphasis readback wrong");

  // read valid, stored bytes, controls one edge later, reset values and clock-enable freeze
  rvalid_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && !cfg_rd) |=> !cfg_rvalid)
    else $error("read valid without a read strobe");
  range_a_hi_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && cfg_wr && cfg_addr == `ACRC_RANGE_A_OFF0)
    |=> range_a_reg[15:8] == $past(cfg_wdata))
    else $error("range a high byte not stored");
  range_a_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> input_a_range_code == $past(range_a_reg))
    else $error("range a code not following register");
  range_b_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> input_b_range_code == $past(range_b_reg))
    else $error("range b code not following register");
  range_b_rst_a: assert property (@(posedge ref_clk)
    !rst_b |=> range_b_reg == 16'ha000 && input_b_range_code == 16'ha000)
    else $error("range b reset value wrong");
  ts_en_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> timestamp_receiver_enable == $past(tstamp_reg[0]))
    else $error("timestamp enable not following control bit");
  device_sample_clock_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> devclock_low_swing_mode == $past(clock_input_control_1_reg[2]))
    else $error("sample clock mode not following register");
  flip_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> sysref_polarity_flip == $past(clock_input_control_1_reg[0]))
    else $error("sysref flip output wrong");
  pos_low_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && cfg_rd && cfg_addr == `ACRC_POS_OFF2)
    |=> cfg_rvalid && cfg_rdata == $past(pos_sync[7:0]))
    else $error("position low byte misread");
  dsel_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> sysref_delay_select == $past(clk_ctrl0_reg[3:0]))
    else $error("delay select not following register");
  lane_mid_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> lane_preemphasis_code[(LANES/2)*4 +: 4]
      == $past(preemph_reg[3:0]))
    else $error("middle lane pre-emphasis wrong");
  enable_freeze_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !clk_en |=> $stable(clock_input_control_1_reg) && $stable(preemph_reg)
      && $stable(cfg_rvalid) && $stable(lane_preemphasis_code))
    else $error("state changed while clock enable low");
endmodule // acrc_cfg_bank
`default_nettype wire

// *** design/acrc_regs.svh ***
/*
  register offsets, field positions and reset values of the clock, range,
  reference, timestamp and lane pre-emphasis configuration bank.
  assumes byte-wide registers on a byte-addressed configuration port.
*/
`ifndef ACRC_REGS_SVH
`define ACRC_REGS_SVH

`define ACRC_ADDR_W          12
`define ACRC_CLK_CTRL0_OFF   12'h029
`define ACRC_CLOCK_INPUT_CONTROL_1_OFF   12'h02a
`define ACRC_POS_OFF0        12'h02c
`define ACRC_POS_OFF1        12'h02d
`define ACRC_POS_OFF2        12'h02e
`define ACRC_RANGE_A_OFF0    12'h030
`define ACRC_RANGE_A_OFF1    12'h031
`define ACRC_RANGE_B_OFF0    12'h032
`define ACRC_RANGE_B_OFF1    12'h033
`define ACRC_BYPASS_OFF      12'h038
`define ACRC_TSTAMP_OFF      12'h03b
`define ACRC_PREEMPH_OFF     12'h048

`define ACRC_CLK_CTRL0_RST   8'h00
`define ACRC_CLOCK_INPUT_CONTROL_1_RST   8'h00
`define ACRC_RANGE_RST       16'ha000
`define ACRC_BYPASS_RST      8'h00
`define ACRC_TSTAMP_RST      8'h00
`define ACRC_PREEMPH_RST     8'h00

`define ACRC_DEVICE_SAMPLE_CLOCK_LS_BIT   2
`define ACRC_SYSREF_LS_BIT   1
`define ACRC_SYSREF_FLIP_BIT 0
`define ACRC_FINE_VIEW_BIT   4
`define ACRC_BYPASS_BIT      0
`define ACRC_TS_LS_BIT       1
`define ACRC_TS_EN_BIT       0
`define ACRC_PE_MSB          3
`define ACRC_SEL_MSB         3

`endif

// *** design/acrc_pkg.sv ***
/*
  types shared by the configuration bank.
  assumes acrc_regs.svh for the numeric constants.
*/
package acrc_pkg;
  typedef logic [7:0]  acrc_byte_t;
  typedef logic [15:0] acrc_range_t;
  typedef logic [23:0] acrc_pos_t;
  typedef logic [3:0]  acrc_code_t;
endpackage

// *** design/acrc_pos_sync.sv ***
/*
  two-flop synchroniser for the edge-position word coming from the
  sample-clock domain, captured only when the word is stable.
  assumes the source holds the word for several config clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module acrc_pos_sync #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] hold_reg;
  logic [WIDTH-1:0] stable_reg;

  // only hold_reg reads meta_reg
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      hold_reg <= '0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      hold_reg <= meta_reg;
    end
  end

  // output only updates when two settled samples agree, so a word
  // caught mid-change never reaches software
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stable_reg <= '0;
      sync_out   <= '0;
    end else if (clk_en) begin
      stable_reg <= hold_reg;
      if (hold_reg == stable_reg) begin
        sync_out <= hold_reg;
      end
    end
  end
endmodule // acrc_pos_sync
`default_nettype wire

// *** bench/acrc_cfg_bank_tb.sv ***
/*
  self-checking bench for the configuration bank: reset values, a write
  and read-back table, read-only position status, clock enable, back to
  back access and the receiver, range and lane controls.
  assumes one-cycle strobes and read data one cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
`include "acrc_regs.svh"
module acrc_cfg_bank_tb;
  import acrc_pkg::*;
  typedef struct {
    logic [11:0] addr;
    acrc_byte_t  wdata;
    acrc_byte_t  rexp;
  } acrc_row_t;
  logic                    ref_clk;
  logic                    rst_b;
  logic                    clk_en;
  logic [`ACRC_ADDR_W-1:0] cfg_addr;
  logic                    cfg_wr;
  logic                    cfg_rd;
  acrc_byte_t              cfg_wdata;
  acrc_byte_t              cfg_rdata;
  logic                    cfg_rvalid;
  acrc_pos_t               sysref_edge_position;
  logic                    sysref_raw;
  logic                    dev_ls, sr_ls, sr_flip, sr_al, fine;
  acrc_code_t              dsel;
  logic                    auto_cal, bypass, ts_ls, ts_en;
  acrc_range_t             range_a, range_b;
  logic [63:0]             lanes;
  acrc_byte_t              rdv;
  int                      err_total;
  int                      compares;
  // unmapped places must read zero whatever was written; reserved bits read back as written
  acrc_row_t rows [0:11] = '{'{12'h02a, 8'hff, 8'hff},
    '{12'h02a, 8'h07, 8'h07}, '{12'h029, 8'h15, 8'h15},
    '{12'h030, 8'h20, 8'h20}, '{12'h031, 8'h00, 8'h00},
    '{12'h032, 8'hff, 8'hff}, '{12'h033, 8'hff, 8'hff},
    '{12'h038, 8'h01, 8'h01}, '{12'h03b, 8'h03, 8'h03},
    '{12'h048, 8'h0a, 8'h0a}, '{12'h040, 8'h55, 8'h00},
    '{12'h02f, 8'h77, 8'h00}};
  logic [11:0] rst_addr [0:8] = '{12'h029, 12'h02a, 12'h030, 12'h031,
    12'h032, 12'h033, 12'h038, 12'h03b, 12'h048};
  acrc_byte_t rst_exp [0:8] = '{8'h00, 8'h00, 8'ha0, 8'h00, 8'ha0,
    8'h00, 8'h00, 8'h00, 8'h00};

  acrc_cfg_bank #(.LANES(16)) DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .sysref_edge_position(sysref_edge_position), .sysref_raw(sysref_raw),
    .devclock_low_swing_mode(dev_ls), .sysref_low_swing_mode(sr_ls),
    .sysref_polarity_flip(sr_flip), .sysref_aligned(sr_al),
    .sysref_position_fine_view(fine), .sysref_delay_select(dsel),
    .sysref_auto_cal(auto_cal), .input_a_range_code(range_a),
    .input_b_range_code(range_b), .reference_bypass_select(bypass),
    .timestamp_low_swing_mode(ts_ls), .timestamp_receiver_enable(ts_en),
    .lane_preemphasis_code(lanes));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input acrc_byte_t d);
    @(posedge ref_clk);
    #1 cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge ref_clk);
    #1 cfg_wr = 1'b0;
  endtask

  // read data is taken in the cycle after the strobe, where it stands
  task automatic rd(input logic [11:0] a, output acrc_byte_t d);
    @(posedge ref_clk);
    #1 cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge ref_clk);
    #1 cfg_rd = 1'b0;
    chk(cfg_rvalid, 1'b1);
    d = cfg_rdata;
  endtask

  // synchroniser latency is fixed at three clocks; the wait is still bounded, at 20 clocks
  task automatic wait_al(input logic exp);
    int n;
    for (n = 0; n < 20 && sr_al !== exp; n++) @(posedge ref_clk);
    #1 chk(sr_al, exp);
    if (sr_al !== exp) test_done();
  endtask

  task automatic check_reset;
    for (int i = 0; i < 9; i++) begin
      rd(rst_addr[i], rdv);
      chk(rdv, rst_exp[i]);
    end
    chk(range_a, 16'ha000);
    chk(range_b, 16'ha000);
    chk(ts_en, 1'b0);
    chk(auto_cal, 1'b1);
    chk({dev_ls, sr_ls, sr_flip, bypass, ts_ls}, 5'h00);
    chk(lanes, 64'h0);
  endtask

  initial begin
    err_total = 0;
    compares = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    cfg_addr = 12'h000;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_wdata = 8'h00;
    sysref_edge_position = 24'hc3a51e;
    sysref_raw = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    check_reset();
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rdv);
      chk(rdv, rows[i].rexp);
    end
    chk(dev_ls, 1'b1);
    chk(sr_ls, 1'b1);
    chk(sr_flip, 1'b1);
    chk(fine, 1'b1);
    chk(dsel, 4'h5);
    chk(auto_cal, 1'b0);
    chk(range_a, 16'h2000);
    chk(range_b, 16'hffff);
    chk(bypass, 1'b1);
    chk(ts_ls, 1'b1);
    chk(ts_en, 1'b1);
    chk(lanes, {16{4'ha}});
    wait_al(1'b1);
    @(posedge ref_clk);
    #1 sysref_raw = 1'b1;
    wait_al(1'b0);
    wr(12'h02a, 8'h00);
    wait_al(1'b1);
    // status is read only: the write must leave the top byte alone
    wr(12'h02c, 8'h00);
    rd(12'h02c, rdv);
    chk(rdv, 8'hc3);
    rd(12'h02d, rdv);
    chk(rdv, 8'ha5);
    rd(12'h02e, rdv);
    chk(rdv, 8'h1e);
    // software picks the delay tap from the position it just read
    wr(12'h029, {4'h1, rdv[3:0]});
    repeat (2) @(posedge ref_clk);
    #1 chk(dsel, 4'he);
    chk(auto_cal, 1'b0);
    @(posedge ref_clk);
    #1 sysref_edge_position = 24'h5a0f96;
    repeat (8) @(posedge ref_clk);
    rd(12'h02e, rdv);
    chk(rdv, 8'h96);
    // a write while the clock enable is low must be dropped
    @(posedge ref_clk);
    #1 clk_en = 1'b0;
    wr(12'h048, 8'h0f);
    clk_en = 1'b1;
    rd(12'h048, rdv);
    chk(rdv, 8'h0a);
    // read in the cycle right after the write sees the new byte
    @(posedge ref_clk);
    #1 cfg_wr = 1'b1;
    cfg_addr = 12'h048;
    cfg_wdata = 8'h03;
    @(posedge ref_clk);
    #1 cfg_wr = 1'b0;
    cfg_rd = 1'b1;
    @(posedge ref_clk);
    #1 cfg_rd = 1'b0;
    chk(cfg_rvalid, 1'b1);
    chk(cfg_rdata, 8'h03);
    chk(lanes, {16{4'h3}});
    wr(12'h029, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk(auto_cal, 1'b1);
    chk(fine, 1'b0);
    // codes below the recommended minimum are still stored
    wr(12'h030, 8'h00);
    rd(12'h030, rdv);
    chk(range_a, 16'h0000);
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    check_reset();
    test_done();
  end
endmodule // acrc_cfg_bank_tb
`default_nettype wire
